// file: hw/npic_regs.svh
`ifndef NPIC_REGS_SVH
`define NPIC_REGS_SVH
// ==========================================
// Register addresses
`define NPIC_ADDR_CC 3'h0
`define NPIC_ADDR_PRIO0 3'h1
`define NPIC_ADDR_PRIO1 3'h2
`define NPIC_ADDR_PRIO2 3'h3
`define NPIC_ADDR_PRIO3 3'h4
`define NPIC_ADDR_SENSE 3'h5
`define NPIC_ADDR_STATUS 3'h6
// ==========================================
// Reset values and fields
`define NPIC_CC_RESET 8'hEA
`define NPIC_PRIO_RESET 8'hFF
`define NPIC_PRIO3_RO_MASK 8'hF0
`define NPIC_SENSE_RESET 8'h00
`define NPIC_SENSE_MASK 8'h3F
`define NPIC_CC_HI_BIT 5
`define NPIC_CC_LO_BIT 3
`define NPIC_LVL_MAIN 2'h2
`define NPIC_LVL_ONE 2'h1
`define NPIC_LVL_TWO 2'h0
`define NPIC_LVL_THREE 2'h3
`define NPIC_VEC_RESET 16'hFFFE
`define NPIC_VEC_TRAP 16'hFFFC
`define NPIC_VEC_BASE 16'hFFFA
`define NPIC_VEC_NONE 4'hF
`define NPIC_EXT_FIRST 2
// Wake masks per vector bit
`define NPIC_WAKE_HALT 13'h001C
`define NPIC_WAKE_AWU 13'h001D
`define NPIC_WAKE_ACTIVE 13'h049C
`endif

// file: hw/npic_pkg.sv
package npic_pkg;
  typedef enum logic [1:0] {
    NPIC_RUN,
    NPIC_HALT,
    NPIC_ACTIVE_HALT,
    NPIC_TIMED_HALT
  } npic_mode_t;
  typedef enum logic [2:0] {
    NPIC_SENSE_FALL_LOW,
    NPIC_SENSE_RISE,
    NPIC_SENSE_FALL,
    NPIC_SENSE_BOTH,
    NPIC_SENSE_OTHER
  } npic_sense_t;
endpackage : npic_pkg

// file: hw/npic_ctrl.sv
`include "npic_regs.svh"
module npic_ctrl #(
  parameter int NUM_VEC = 13
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [NUM_VEC-1:0] irq_req,
  input wire logic [NUM_VEC-1:0] irq_enable,
  input wire logic [2:0] ext_pin,
  input wire logic trap_instr,
  input wire logic irq_unmask_instr,
  input wire logic irq_mask_instr,
  input wire logic wait_for_irq_instr,
  input wire logic halt_instr,
  input wire logic active_halt_sel,
  input wire logic timed_halt_sel,
  input wire logic irq_return_instr,
  input wire logic pop_cc_instr,
  input wire logic [7:0] stack_cc,
  input wire logic entry_ready,
  output logic entry_valid,
  output logic [15:0] entry_vector,
  output logic [7:0] condition_code_reg,
  output logic jump_if_masked,
  output logic jump_if_unmasked,
  output logic halt_wake
);
  initial begin
    if (NUM_VEC != 13) begin
      $error("npic_ctrl serves exactly 13 vectors");
    end
  end

  // ==========================================
  // State
  typedef struct packed {
    logic [7:0] cc;
    logic [3:0][7:0] prio;
    logic [7:0] sense;
    logic [2:0] ext_s1;
    logic [2:0] ext_s2;
    logic [2:0] ext_d;
    logic [2:0] ext_lat;
    logic [NUM_VEC-1:0] active;
    logic trap_pend;
    logic boot;
    npic_pkg::npic_mode_t mode;
    logic [7:0] rdata;
    logic valid;
    logic [15:0] vector;
  } npic_state_t;

  npic_state_t st_r;
  npic_state_t st_nxt;

  function automatic logic [2:0] npic_rank(input logic [1:0] pair);
    case (pair)
      `NPIC_LVL_MAIN: npic_rank = 3'h0;
      `NPIC_LVL_ONE: npic_rank = 3'h1;
      `NPIC_LVL_TWO: npic_rank = 3'h2;
      default: npic_rank = 3'h3;
    endcase
  endfunction : npic_rank

  function automatic logic [1:0] npic_pair(input logic [3:0][7:0] p, input int n);
    logic [7:0] r;
    r = p[n / 4];
    npic_pair = r[2 * (n % 4) +: 2];
  endfunction : npic_pair

  function automatic npic_pkg::npic_sense_t npic_decode(input logic [1:0] f);
    case (f)
      2'h0: npic_decode = npic_pkg::NPIC_SENSE_FALL_LOW;
      2'h1: npic_decode = npic_pkg::NPIC_SENSE_RISE;
      2'h2: npic_decode = npic_pkg::NPIC_SENSE_FALL;
      2'h3: npic_decode = npic_pkg::NPIC_SENSE_BOTH;
      default: npic_decode = npic_pkg::NPIC_SENSE_OTHER;
    endcase
  endfunction : npic_decode

  logic [1:0] cur_pair;
  logic [1:0] win_pair;
  logic [2:0] ext_level;
  logic [NUM_VEC-1:0] pending;
  logic [NUM_VEC-1:0] wake_mask;
  logic [3:0] win;
  logic [2:0] win_rank;
  logic [7:0] wr_merge;
  logic cur_prio_high;
  logic cur_prio_low;

  always_comb begin
    st_nxt = st_r;
    cur_prio_high = st_r.cc[`NPIC_CC_HI_BIT];
    cur_prio_low = st_r.cc[`NPIC_CC_LO_BIT];
    cur_pair = {cur_prio_high, cur_prio_low};
    win_pair = 2'h0;
    ext_level = 3'h0;
    wr_merge = 8'h00;
    win = `NPIC_VEC_NONE;
    win_rank = 3'h0;
    // ==========================================
    // External line sensing
    st_nxt.ext_s1 = ext_pin;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_d = st_r.ext_s2;
    for (int i = 0; i < 3; i++) begin
      case (npic_decode(st_r.sense[2 * i +: 2]))
        npic_pkg::NPIC_SENSE_FALL_LOW: ext_level[i] = ~st_r.ext_s2[i];
        npic_pkg::NPIC_SENSE_RISE: st_nxt.ext_lat[i] = st_r.ext_lat[i] |
          (st_r.ext_s2[i] & ~st_r.ext_d[i]);
        npic_pkg::NPIC_SENSE_FALL: st_nxt.ext_lat[i] = st_r.ext_lat[i] |
          (~st_r.ext_s2[i] & st_r.ext_d[i]);
        npic_pkg::NPIC_SENSE_BOTH: st_nxt.ext_lat[i] = st_r.ext_lat[i] |
          (st_r.ext_s2[i] ^ st_r.ext_d[i]);
        default: ext_level[i] = 1'b0;
      endcase
      if (npic_decode(st_r.sense[2 * i +: 2]) == npic_pkg::NPIC_SENSE_FALL_LOW) begin
        ext_level[i] = ~st_r.ext_s2[i];
      end
    end
    // Ports A, B, C on vectors 2 to 4
    pending = irq_req & irq_enable;
    pending[`NPIC_EXT_FIRST +: 3] = (st_r.ext_lat | ext_level) &
      irq_enable[`NPIC_EXT_FIRST +: 3];
    // ==========================================
    // Wake capability
    // Awu only from timed halt
    case (st_r.mode)
      npic_pkg::NPIC_HALT: wake_mask = `NPIC_WAKE_HALT;
      npic_pkg::NPIC_ACTIVE_HALT: wake_mask = `NPIC_WAKE_ACTIVE;
      npic_pkg::NPIC_TIMED_HALT: wake_mask = `NPIC_WAKE_AWU;
      default: wake_mask = {NUM_VEC{1'b1}};
    endcase
    halt_wake = (st_r.mode != npic_pkg::NPIC_RUN) && |(pending & wake_mask);
    // ==========================================
    // Arbitration
    for (int n = NUM_VEC - 1; n >= 0; n--) begin
      if (pending[n] && (st_r.mode == npic_pkg::NPIC_RUN || wake_mask[n]) &&
          npic_rank(npic_pair(st_r.prio, n)) > npic_rank(cur_pair) &&
          npic_rank(npic_pair(st_r.prio, n)) >= win_rank) begin
        win = 4'(n);
        win_rank = npic_rank(npic_pair(st_r.prio, n));
      end
    end
    // ==========================================
    // Instructions
    // Priority loading instructions
    if (irq_unmask_instr || wait_for_irq_instr || halt_instr) begin
      st_nxt.cc[`NPIC_CC_HI_BIT] = 1'b1;
      st_nxt.cc[`NPIC_CC_LO_BIT] = 1'b0;
    end
    if (irq_mask_instr) begin
      st_nxt.cc[`NPIC_CC_HI_BIT] = 1'b1;
      st_nxt.cc[`NPIC_CC_LO_BIT] = 1'b1;
    end
    if (halt_instr) begin
      st_nxt.mode = timed_halt_sel ? npic_pkg::NPIC_TIMED_HALT :
        active_halt_sel ? npic_pkg::NPIC_ACTIVE_HALT : npic_pkg::NPIC_HALT;
    end
    if (irq_return_instr || pop_cc_instr) begin
      st_nxt.cc = stack_cc;
      st_nxt.active = st_r.active & (st_r.active - 1'b1);
    end
    if (trap_instr) begin
      st_nxt.trap_pend = 1'b1;
    end
    // ==========================================
    // Register writes
    if (reg_write) begin
      case (reg_addr)
        `NPIC_ADDR_CC: st_nxt.cc = reg_wdata;
        `NPIC_ADDR_PRIO0, `NPIC_ADDR_PRIO1, `NPIC_ADDR_PRIO2, `NPIC_ADDR_PRIO3: begin
          for (int k = 0; k < 4; k++) begin
            wr_merge[2 * k +: 2] = (reg_wdata[2 * k +: 2] == `NPIC_LVL_MAIN) ?
              st_r.prio[reg_addr - `NPIC_ADDR_PRIO0][2 * k +: 2] : reg_wdata[2 * k +: 2];
          end
          if (reg_addr == `NPIC_ADDR_PRIO3) begin
            wr_merge = wr_merge | `NPIC_PRIO3_RO_MASK;
          end
          // New pair used at next arbitration
          st_nxt.prio[reg_addr - `NPIC_ADDR_PRIO0] = wr_merge;
        end
        `NPIC_ADDR_SENSE: begin
          if (st_r.cc[`NPIC_CC_HI_BIT] && st_r.cc[`NPIC_CC_LO_BIT]) begin
            st_nxt.sense = reg_wdata & `NPIC_SENSE_MASK;
            for (int i = 0; i < 3; i++) begin
              if (reg_wdata[2 * i +: 2] != st_r.sense[2 * i +: 2]) begin
                st_nxt.ext_lat[i] = 1'b0;
              end
            end
          end
        end
        default: st_nxt.cc = st_nxt.cc;
      endcase
    end
    // ==========================================
    // Entry
    st_nxt.valid = 1'b0;
    if (st_r.valid && !entry_ready) begin
      st_nxt.valid = 1'b1;
    end else if (st_r.boot || st_r.trap_pend) begin
      st_nxt.valid = 1'b1;
      st_nxt.vector = st_r.boot ? `NPIC_VEC_RESET : `NPIC_VEC_TRAP;
      st_nxt.boot = 1'b0;
      st_nxt.trap_pend = st_r.boot & st_r.trap_pend;
      st_nxt.cc[`NPIC_CC_HI_BIT] = 1'b1;
      st_nxt.cc[`NPIC_CC_LO_BIT] = 1'b1;
    end else if (win != `NPIC_VEC_NONE && !st_r.valid) begin
      st_nxt.valid = 1'b1;
      st_nxt.vector = `NPIC_VEC_BASE - {11'h000, win, 1'b0};
      win_pair = npic_pair(st_r.prio, int'(win));
      st_nxt.cc[`NPIC_CC_HI_BIT] = win_pair[1];
      st_nxt.cc[`NPIC_CC_LO_BIT] = win_pair[0];
      st_nxt.active = st_r.active | (NUM_VEC'(1) << win);
      st_nxt.mode = npic_pkg::NPIC_RUN;
      if (win >= `NPIC_EXT_FIRST && win < `NPIC_EXT_FIRST + 3) begin
        st_nxt.ext_lat[win - `NPIC_EXT_FIRST] = 1'b0;
      end
    end
    // ==========================================
    // Read path
    case (reg_addr)
      `NPIC_ADDR_CC: st_nxt.rdata = st_r.cc;
      `NPIC_ADDR_PRIO0: st_nxt.rdata = st_r.prio[0];
      `NPIC_ADDR_PRIO1: st_nxt.rdata = st_r.prio[1];
      `NPIC_ADDR_PRIO2: st_nxt.rdata = st_r.prio[2];
      `NPIC_ADDR_PRIO3: st_nxt.rdata = st_r.prio[3];
      `NPIC_ADDR_SENSE: st_nxt.rdata = st_r.sense;
      `NPIC_ADDR_STATUS: st_nxt.rdata = {5'h00, halt_wake, st_r.mode};
      default: st_nxt.rdata = 8'h00;
    endcase
    if (!reg_read) begin
      st_nxt.rdata = 8'h00;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r.cc <= `NPIC_CC_RESET;
      st_r.prio <= {4{`NPIC_PRIO_RESET}};
      st_r.sense <= `NPIC_SENSE_RESET;
      st_r.ext_s1 <= 3'h7;
      st_r.ext_s2 <= 3'h7;
      st_r.ext_d <= 3'h7;
      st_r.ext_lat <= 3'h0;
      st_r.active <= '0;
      st_r.trap_pend <= 1'b0;
      st_r.boot <= 1'b1;
      st_r.mode <= npic_pkg::NPIC_RUN;
      st_r.rdata <= 8'h00;
      st_r.valid <= 1'b0;
      st_r.vector <= 16'h0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign reg_rdata = st_r.rdata;
  assign entry_valid = st_r.valid;
  assign entry_vector = st_r.vector;
  assign condition_code_reg = st_r.cc;
  assign jump_if_masked = st_r.cc[`NPIC_CC_HI_BIT] & st_r.cc[`NPIC_CC_LO_BIT];
  assign jump_if_unmasked = ~(st_r.cc[`NPIC_CC_HI_BIT] & st_r.cc[`NPIC_CC_LO_BIT]);
endmodule : npic_ctrl

// file: test/npic_properties.sv
// ==========================================
// Port checker
module npic_properties (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic trap_instr,
  input wire logic irq_unmask_instr,
  input wire logic irq_mask_instr,
  input wire logic wait_for_irq_instr,
  input wire logic halt_instr,
  input wire logic irq_return_instr,
  input wire logic pop_cc_instr,
  input wire logic [7:0] stack_cc,
  input wire logic entry_ready,
  input wire logic entry_valid,
  input wire logic [15:0] entry_vector,
  input wire logic [7:0] condition_code_reg,
  input wire logic jump_if_masked,
  input wire logic jump_if_unmasked
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence s_trap_seen;
    trap_instr && !entry_valid;
  endsequence
  sequence s_trap_entry;
    ##2 (entry_valid && entry_vector == 16'hFFFC);
  endsequence
  a_trap_entry_time: assert property (s_trap_seen |-> s_trap_entry)
    else $error("trap entry late or wrong");
  a_entry_held: assert property (entry_valid && !entry_ready |=> entry_valid && $stable(entry_vector))
    else $error("entry dropped before accept");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_jump_flags: assert property (jump_if_masked == (condition_code_reg[5] && condition_code_reg[3])
    && jump_if_unmasked == !jump_if_masked) else $error("jump flags wrong");
  a_level_zero: assert property ((irq_unmask_instr || wait_for_irq_instr || halt_instr)
    && !entry_valid |=> condition_code_reg[5] && !condition_code_reg[3]) else $error("not level 0");
  a_level_three: assert property (irq_mask_instr |=> condition_code_reg[5] && condition_code_reg[3])
    else $error("not level 3");
  a_stack_load: assert property ((pop_cc_instr || irq_return_instr) && !entry_valid |=>
    condition_code_reg[5] == $past(stack_cc[5]) && condition_code_reg[3] == $past(stack_cc[3]))
    else $error("stack image not loaded");
  a_nmi_level: assert property ($rose(entry_valid) && entry_vector >= 16'hFFFC |->
    condition_code_reg[5] && condition_code_reg[3]) else $error("nmi level not 3");
  a_vector_range: assert property (entry_valid |-> !entry_vector[0] && entry_vector >= 16'hFFE2)
    else $error("vector out of range");
endmodule : npic_properties
bind npic_ctrl npic_properties npic_properties_i (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .trap_instr(trap_instr),
  .irq_unmask_instr(irq_unmask_instr), .irq_mask_instr(irq_mask_instr),
  .wait_for_irq_instr(wait_for_irq_instr), .halt_instr(halt_instr),
  .irq_return_instr(irq_return_instr), .pop_cc_instr(pop_cc_instr), .stack_cc(stack_cc),
  .entry_ready(entry_ready), .entry_valid(entry_valid), .entry_vector(entry_vector),
  .condition_code_reg(condition_code_reg), .jump_if_masked(jump_if_masked),
  .jump_if_unmasked(jump_if_unmasked));

// file: test/npic_cpu_model.sv
// ==========================================
// CPU entry acceptance, lat cycles late
module npic_cpu_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic entry_valid,
  input wire logic [1:0] lat,
  output logic entry_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 2'h0;
    end else if (!entry_valid || entry_ready) begin
      wait_r <= 2'h0;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
  assign entry_ready = entry_valid && (wait_r >= lat);
endmodule : npic_cpu_model

// file: test/npic_ctrl_tb.sv
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module npic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [2:0] reg_addr = 3'h0, ext_pin = 3'h7;
  logic [7:0] reg_wdata = 8'h00, stack_cc = 8'hE2, reg_rdata, condition_code_reg;
  logic [12:0] irq_req = 13'h0000, irq_enable = 13'h0000;
  logic [6:0] ins = 7'h00;
  logic [1:0] lat = 2'h0;
  logic [1:0] hsel = 2'h0;
  logic entry_ready, entry_valid, jump_if_masked, jump_if_unmasked, halt_wake;
  logic [15:0] entry_vector;
  int n_errors = 0, total_checks = 0, cycles = 0;
  npic_ctrl #(.NUM_VEC(13)) npic_ctrl_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_enable(irq_enable), .ext_pin(ext_pin),
    .trap_instr(ins[4]), .irq_unmask_instr(ins[0]), .irq_mask_instr(ins[3]),
    .wait_for_irq_instr(ins[1]), .halt_instr(ins[2]), .active_halt_sel(hsel[0]),
    .timed_halt_sel(hsel[1]), .irq_return_instr(ins[5]), .pop_cc_instr(ins[6]),
    .stack_cc(stack_cc), .entry_ready(entry_ready), .entry_valid(entry_valid),
    .entry_vector(entry_vector), .condition_code_reg(condition_code_reg),
    .jump_if_masked(jump_if_masked), .jump_if_unmasked(jump_if_unmasked), .halt_wake(halt_wake));
  npic_cpu_model npic_cpu_model_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .entry_valid(entry_valid), .lat(lat), .entry_ready(entry_ready));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Bus and handshake tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    `CHK(nm, e, reg_rdata)
    @(posedge clk_sys);
  endtask : rd
  task automatic pulse(input int k);
    ins <= 7'h01 << k;
    @(posedge clk_sys);
    ins <= 7'h00;
    @(posedge clk_sys);
  endtask : pulse
  task automatic wait_entry(input logic [15:0] e, input logic [1:0] p);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (!(entry_valid === 1'b1 && entry_ready === 1'b1) && n < 50) begin
      n++;
      @(negedge clk_sys);
    end
    `CHK("vector", e, entry_vector)
    `CHK("cur_prio", p, {condition_code_reg[5], condition_code_reg[3]})
    @(posedge clk_sys);
  endtask : wait_entry
  task automatic no_entry();
    repeat (8) begin
      @(negedge clk_sys);
      `CHK("idle", 1'b0, entry_valid)
    end
    @(posedge clk_sys);
  endtask : no_entry
  // ==========================================
  // Scenarios
  task automatic t_regs();
    @(negedge clk_sys);
    `CHK("cc", 8'hEA, condition_code_reg & 8'hEF)
    @(posedge clk_sys);
    for (int a = 1; a < 5; a++) begin
      rd(a[2:0], 8'hFF, "prio");
    end
    rd(3'h5, 8'h00, "sense");
    rd(3'h7, 8'h00, "unmapped");
    $display("test regs done");
  endtask : t_regs
  task automatic t_prio();
    wr(3'h1, 8'hCF);
    wr(3'h1, 8'h64);
    rd(3'h1, 8'h44, "prio0");
    wr(3'h4, 8'h00);
    rd(3'h4, 8'hF0, "prio3");
    $display("test prio done");
  endtask : t_prio
  task automatic t_sense();
    wr(3'h5, 8'h15);
    rd(3'h5, 8'h15, "sense");
    pulse(0);
    wr(3'h5, 8'h3F);
    rd(3'h5, 8'h15, "sense_locked");
    pulse(3);
    @(posedge clk_sys);
    $display("test sense done");
  endtask : t_sense
  task automatic t_trap();
    lat <= 2'h3;
    pulse(4);
    wait_entry(16'hFFFC, 2'h3);
    lat <= 2'h0;
    $display("test trap done");
  endtask : t_trap
  task automatic t_nest();
    irq_enable <= 13'h0062;
    irq_req <= 13'h0062;
    pulse(0);
    wait_entry(16'hFFF0, 2'h3);
    irq_req[5] <= 1'b0;
    pulse(5);
    wait_entry(16'hFFEE, 2'h3);
    irq_req[6] <= 1'b0;
    pulse(5);
    wait_entry(16'hFFF8, 2'h1);
    irq_req <= 13'h0000;
    pulse(5);
    @(posedge clk_sys);
    $display("test nest done");
  endtask : t_nest
  task automatic t_ext();
    ext_pin[0] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ext_pin[0] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pulse(3);
    wr(3'h5, 8'h16);
    irq_enable[2] <= 1'b1;
    pulse(0);
    no_entry();
    ext_pin[0] <= 1'b0;
    wait_entry(16'hFFF6, 2'h0);
    pulse(5);
    no_entry();
    $display("test ext done");
  endtask : t_ext
  task automatic t_instr();
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      @(negedge clk_sys);
      `CHK("cur_prio", (k == 3) ? 2'h3 : 2'h2, {condition_code_reg[5], condition_code_reg[3]})
      `CHK("jump_masked", k == 3, jump_if_masked)
      @(posedge clk_sys);
    end
    pulse(6);
    @(negedge clk_sys);
    `CHK("pop_cc", 2'h2, {condition_code_reg[5], condition_code_reg[3]})
    @(posedge clk_sys);
    rd(3'h6, 8'h01, "status");
    $display("test instr done");
  endtask : t_instr
  task automatic t_wake();
    irq_enable <= 13'h01A0;
    irq_req <= 13'h0120;
    hsel <= 2'h1;
    pulse(2);
    no_entry();
    rd(3'h6, 8'h02, "status_active");
    irq_req[7] <= 1'b1;
    @(negedge clk_sys);
    `CHK("halt_wake", 1'b1, halt_wake)
    wait_entry(16'hFFEC, 2'h3);
    irq_req <= 13'h0000;
    pulse(5);
    pulse(3);
    irq_enable <= 13'h0001;
    irq_req <= 13'h0001;
    hsel <= 2'h0;
    pulse(2);
    no_entry();
    hsel <= 2'h2;
    pulse(2);
    wait_entry(16'hFFFA, 2'h0);
    irq_req <= 13'h0000;
    hsel <= 2'h0;
    pulse(5);
    $display("test wake done");
  endtask : t_wake
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    wait_entry(16'hFFFE, 2'h3);
    t_regs();
    t_prio();
    t_sense();
    t_trap();
    t_nest();
    t_ext();
    t_instr();
    t_wake();
    stop_test();
  end
endmodule : npic_ctrl_tb
